// ===== src/scs_consts.svh
// Timing counts and field positions shared by both ends of the conversion sequencer
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_CLK_HZ 10000000
`define SCS_ACQ_CCLKS 3
`define SCS_CONV_CCLKS 18
`define SCS_CYCLE_CCLKS 21
`define SCS_START_LOW_NS 40
`define SCS_START_LOW_CYC ((`SCS_START_LOW_NS * (`SCS_CLK_HZ / 1000000) + 999) / 1000 < 1 ? 1 : \
    (`SCS_START_LOW_NS * (`SCS_CLK_HZ / 1000000) + 999) / 1000)
`define SCS_RES_BITS 14
`define SCS_CMD_BITS 4
`define SCS_CFG_BITS 12
`define SCS_CFG_AUTO_CH_BIT 11
`define SCS_CFG_TRIG_BIT 9
`define SCS_CFG_SRC_BIT 10
`define SCS_CFG_TAG_BIT 1
`define SCS_CFG_RESET 12'hfff
`define SCS_CMD_SEL_CH0 4'h0
`define SCS_CMD_SEL_CH1 4'h1
`define SCS_CMD_WRITE_CFG 4'he
`define SCS_CMD_DEFAULT 4'hf
`define SCS_APB_CTRL 8'h00
`define SCS_APB_CFG 8'h04
`define SCS_APB_STAT 8'h08
`define SCS_APB_MASK 8'h0c
`define SCS_APB_RESULT 8'h10
`define SCS_APB_CMD 8'h14
`endif

// ===== src/scs_pkg.sv
// Types used by the converter end of the conversion sequencer
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_IDLE,
        SCS_ACQ,
        SCS_CONV
    } scs_phase_e;
    typedef logic [13:0] scs_result_t;
endpackage : scs_pkg

// ===== src/scs_link_if.sv
// Link between host and converter sequencer: start pin, serial clock and command word
`timescale 1ns/1ns
interface scs_link_if;
    logic conversion_start_n;
    logic frame_select_n;
    logic sclk;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic [11:0] cmd_data;
    logic [13:0] result;
    logic result_tag;
    logic end_of_conversion_n;
    logic result_valid;
    modport device (
        input conversion_start_n, frame_select_n, sclk, cmd_valid, cmd_code, cmd_data,
        output result, result_tag, end_of_conversion_n, result_valid
    );
    modport host (
        output conversion_start_n, frame_select_n, sclk, cmd_valid, cmd_code, cmd_data,
        input result, result_tag, end_of_conversion_n, result_valid
    );
endinterface : scs_link_if

// ===== src/scs_device.sv
// Converter end: conversion clock choice, acquisition and conversion timing, channel sequencing
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "scs_consts.svh"
module scs_device #(
    parameter int OSC_DIV = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Link
    scs_link_if.device link,
    // Analog core model
    input wire logic [13:0] sample_ch0_i,
    input wire logic [13:0] sample_ch1_i,
    output logic channel_o,
    output logic holding_o,
    output logic osc_running_o
);
    // Pin synchronisers: change counts when stages two and three agree
    logic [2:0] start_sync;
    logic [2:0] sclk_sync;
    logic start_n;
    logic sclk_lvl;
    logic sclk_lvl_q;
    logic start_n_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_sync <= 3'h7;
            sclk_sync <= 3'h0;
            start_n <= 1'b1;
            sclk_lvl <= 1'b0;
            sclk_lvl_q <= 1'b0;
            start_n_q <= 1'b1;
        end else begin
            start_sync <= {start_sync[1:0], link.conversion_start_n};
            sclk_sync <= {sclk_sync[1:0], link.sclk};
            if (start_sync[1] == start_sync[2]) start_n <= start_sync[2];
            if (sclk_sync[1] == sclk_sync[2]) sclk_lvl <= sclk_sync[2];
            sclk_lvl_q <= sclk_lvl;
            start_n_q <= start_n;
        end
    end
    // Frame select is deliberately not used for the start path
    wire start_fall = start_n_q & ~start_n;
    wire sclk_rise = ~sclk_lvl_q & sclk_lvl;

    // Configuration and command handling
    logic [11:0] cfg;
    logic manual_ch;
    logic auto_first;
    wire cfg_wr = link.cmd_valid & (link.cmd_code == `SCS_CMD_WRITE_CFG);
    wire cfg_def = link.cmd_valid & (link.cmd_code == `SCS_CMD_DEFAULT);
    wire sel_wr = link.cmd_valid & (link.cmd_code[3:1] == 3'h0);
    wire auto_ch = cfg[`SCS_CFG_AUTO_CH_BIT];
    wire auto_trig = ~cfg[`SCS_CFG_TRIG_BIT];
    wire use_sclk = ~cfg[`SCS_CFG_SRC_BIT];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg <= `SCS_CFG_RESET;
            manual_ch <= 1'b0;
        end else if (cfg_wr) begin
            cfg <= link.cmd_data;
        end else if (cfg_def) begin
            cfg <= `SCS_CFG_RESET;
        end else if (sel_wr) begin
            manual_ch <= link.cmd_code[0];
        end
    end

    // Conversion clock tick: oscillator divider or serial clock halved
    logic [7:0] osc_cnt;
    logic sclk_half;
    wire osc_on = ~use_sclk;
    wire osc_tick = osc_on & (osc_cnt == 8'(OSC_DIV - 1));
    wire sclk_tick = use_sclk & sclk_rise & sclk_half;
    wire conversion_clock_tick = osc_tick | sclk_tick;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_cnt <= 8'h00;
            sclk_half <= 1'b0;
        end else begin
            osc_cnt <= (!osc_on || osc_tick) ? 8'h00 : osc_cnt + 8'h01;
            // A manual start realigns the halved serial clock so a conversion spans 36 serial clocks
            if (use_sclk && ~auto_trig && start_fall) begin
                sclk_half <= 1'b0;
            end else if (use_sclk && sclk_rise) begin
                sclk_half <= ~sclk_half;
            end
        end
    end

    // Sequencer
    scs_pkg::scs_phase_e phase;
    logic [4:0] cnt;
    logic ch;
    logic next_auto_ch;
    wire [4:0] acq_last = 5'(`SCS_ACQ_CCLKS - 1);
    wire [4:0] conv_last = 5'(`SCS_CONV_CCLKS - 1);
    wire manual_go = ~auto_trig & start_fall;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase <= scs_pkg::SCS_ACQ;
            cnt <= 5'h00;
            ch <= 1'b0;
            next_auto_ch <= 1'b0;
            auto_first <= 1'b1;
            link.result <= 14'h0000;
            link.result_tag <= 1'b0;
            link.result_valid <= 1'b0;
        end else begin
            link.result_valid <= 1'b0;
            if (cfg_wr && link.cmd_data[`SCS_CFG_AUTO_CH_BIT]) auto_first <= 1'b1;
            unique case (phase)
                scs_pkg::SCS_IDLE, scs_pkg::SCS_ACQ: begin
                    if (phase == scs_pkg::SCS_ACQ && conversion_clock_tick && cnt != acq_last) cnt <= cnt + 5'h01;
                    if (manual_go || (auto_trig && phase == scs_pkg::SCS_ACQ && conversion_clock_tick &&
                        cnt == acq_last)) begin
                        phase <= scs_pkg::SCS_CONV;
                        cnt <= 5'h00;
                        if (auto_ch) begin
                            ch <= auto_first ? 1'b0 : next_auto_ch;
                            next_auto_ch <= auto_first ? 1'b1 : ~next_auto_ch;
                            auto_first <= 1'b0;
                        end else begin
                            ch <= manual_ch;
                        end
                    end
                end
                scs_pkg::SCS_CONV: begin
                    if (conversion_clock_tick) begin
                        if (cnt == conv_last) begin
                            phase <= scs_pkg::SCS_ACQ;
                            cnt <= 5'h00;
                            link.result <= ch ? sample_ch1_i : sample_ch0_i;
                            link.result_tag <= ch & cfg[`SCS_CFG_TAG_BIT];
                            link.result_valid <= 1'b1;
                        end else begin
                            cnt <= cnt + 5'h01;
                        end
                    end
                end
                default: phase <= scs_pkg::SCS_ACQ;
            endcase
        end
    end
    assign link.end_of_conversion_n = (phase != scs_pkg::SCS_CONV);
    assign channel_o = ch;
    assign holding_o = (phase == scs_pkg::SCS_CONV);
    assign osc_running_o = osc_on;
endmodule : scs_device

// ===== src/scs_host.sv
// Host end: APB registers driving start pin, serial clock and commands
`timescale 1ns/1ns
`include "scs_consts.svh"
module scs_host #(
    parameter int SCLK_HALF = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    // Link
    scs_link_if.host link
);
    localparam int LOW_CYC = `SCS_START_LOW_CYC;
    logic [11:0] cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    logic sclk_run;
    logic [7:0] sclk_cnt;
    logic [3:0] low_cnt;
    logic eoc_q;
    wire acc = psel_i & penable_i;
    wire wr = acc & pwrite_i;
    wire wr_ctrl = wr & (paddr_i == `SCS_APB_CTRL);
    wire wr_cfg = wr & (paddr_i == `SCS_APB_CFG);
    wire wr_stat = wr & (paddr_i == `SCS_APB_STAT);
    wire wr_mask = wr & (paddr_i == `SCS_APB_MASK);
    wire wr_cmd = wr & (paddr_i == `SCS_APB_CMD);
    wire start_req = wr_ctrl & pwdata_i[0] & (low_cnt == 4'h0);
    wire conv_done = link.result_valid;
    wire eoc_fall = eoc_q & ~link.end_of_conversion_n;
    wire mapped = (paddr_i[7:5] == 3'h0) & (paddr_i[1:0] == 2'h0) & (paddr_i[4:2] < 3'h6);
    assign pready_o = 1'b1;
    assign pslverr_o = acc & ~mapped;
    assign irq_o = |(stat & mask);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg <= `SCS_CFG_RESET;
            stat <= 2'h0;
            mask <= 2'h0;
            sclk_run <= 1'b0;
            sclk_cnt <= 8'h00;
            low_cnt <= 4'h0;
            eoc_q <= 1'b1;
            prdata_o <= 32'h0000_0000;
            link.conversion_start_n <= 1'b1;
            link.frame_select_n <= 1'b1;
            link.sclk <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.cmd_code <= 4'h0;
            link.cmd_data <= 12'h000;
        end else begin
            eoc_q <= link.end_of_conversion_n;
            link.cmd_valid <= 1'b0;
            if (wr_ctrl) sclk_run <= pwdata_i[1];
            if (sclk_run) begin
                sclk_cnt <= (sclk_cnt == 8'(SCLK_HALF - 1)) ? 8'h00 : sclk_cnt + 8'h01;
                if (sclk_cnt == 8'(SCLK_HALF - 1)) link.sclk <= ~link.sclk;
            end
            // Start pulse is held low long enough for the device to see it
            if (start_req) begin
                link.conversion_start_n <= 1'b0;
                low_cnt <= 4'(LOW_CYC + 2);
            end else if (low_cnt != 4'h0) begin
                low_cnt <= low_cnt - 4'h1;
                if (low_cnt == 4'h1) link.conversion_start_n <= 1'b1;
            end
            if (wr_cfg) cfg <= pwdata_i[11:0];
            if (wr_cmd) begin
                link.cmd_valid <= 1'b1;
                link.cmd_code <= pwdata_i[15:12];
                link.cmd_data <= pwdata_i[11:0];
            end
            if (wr_mask) mask <= pwdata_i[1:0];
            // Set wins over write-one-to-clear
            stat <= (stat & ~({2{wr_stat}} & pwdata_i[1:0])) | {eoc_fall, conv_done};
            unique case (paddr_i)
                `SCS_APB_CTRL: prdata_o <= {30'h0, sclk_run, (low_cnt != 4'h0)};
                `SCS_APB_CFG: prdata_o <= {20'h0, cfg};
                `SCS_APB_STAT: prdata_o <= {29'h0, ~link.end_of_conversion_n, stat};
                `SCS_APB_MASK: prdata_o <= {30'h0, mask};
                `SCS_APB_RESULT: prdata_o <= {17'h0, link.result_tag, 14'h0 | link.result};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule : scs_host

// ===== dv/scs_link_props.sv
// Checker on the host-to-converter link
`timescale 1ns/1ns
`include "scs_consts.svh"
module scs_link_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Link
    input wire logic conversion_start_n,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [11:0] cmd_data,
    input wire logic result_tag,
    input wire logic end_of_conversion_n,
    input wire logic result_valid
);
    logic [7:0] lo_cnt, since;
    logic man, ach, seen, last_tag;
    wire cfg_wr = cmd_valid && cmd_code == `SCS_CMD_WRITE_CFG;
    wire dflt = cmd_valid && cmd_code == `SCS_CMD_DEFAULT;
    wire eoc = end_of_conversion_n;
    wire st = conversion_start_n;
    // Mode copies follow the command stream, as the device registers are not visible here
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lo_cnt <= 8'h00;
            since <= 8'hff;
            {man, ach, seen, last_tag} <= 4'hc;
        end else begin
            lo_cnt <= eoc ? 8'h00 : lo_cnt + 8'h01;
            since <= $fell(st) ? 8'h00 : since + 8'(since != 8'hff);
            man <= cfg_wr ? cmd_data[`SCS_CFG_TRIG_BIT] : man | dflt;
            ach <= cfg_wr ? cmd_data[`SCS_CFG_AUTO_CH_BIT] : ach | dflt;
            seen <= !cmd_valid && (seen | result_valid);
            last_tag <= result_valid ? result_tag : last_tag;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_len; $rose(eoc) |-> lo_cnt == 8'd18 || lo_cnt inside {[8'd141:8'd144]}; endproperty
    a_len: assert property (p_len) else $error("conversion length");
    property p_start; man && $fell(st) && eoc |-> ##[1:20] !eoc; endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_pin; man && $past(man) && $fell(eoc) |-> since <= 8'd20; endproperty
    a_pin: assert property (p_pin) else $error("start without pin");
    property p_gap; !man && $rose(eoc) |-> (eoc || man) [*3] ##1 (!eoc || man); endproperty
    a_gap: assert property (p_gap) else $error("auto gap");
    property p_pulse; result_valid |=> !result_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("result pulse");
    property p_end; $rose(eoc) |-> ##[0:1] result_valid; endproperty
    a_end: assert property (p_end) else $error("no result");
    property p_width; $fell(st) |-> !st [*3]; endproperty
    a_width: assert property (p_width) else $error("start width");
    property p_alt; result_valid && ach && seen |-> result_tag != last_tag; endproperty
    a_alt: assert property (p_alt) else $error("channel order");
    c_auto: cover property (!man && $rose(eoc));
    c_long: cover property ($rose(eoc) && lo_cnt > 8'd100);
    c_tag: cover property (result_valid && result_tag);
endmodule : scs_link_props

// ===== dv/tb_top.sv
// Bench: host and converter joined over the link, driven over APB
`timescale 1ns/1ns
`include "scs_consts.svh"
module tb_top;
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [13:0] s0 = 14'h0, s1 = 14'h0;
    logic pready, pslverr, irq, err, ch, osc;
    int error_cnt = 0, n_tests = 0, lo = 0, hi = 0, last_lo = 0, last_hi = 0, nxt = 0, mask = 0, c, i;
    scs_link_if link ();
    always #50 clk_i = ~clk_i;
    scs_host scs_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq), .link(link.host));
    scs_device scs_device_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link.device), .sample_ch0_i(s0),
        .sample_ch1_i(s1), .channel_o(ch), .holding_o(), .osc_running_o(osc));
    scs_link_props scs_link_props_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .conversion_start_n(link.conversion_start_n), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .cmd_data(link.cmd_data), .result_tag(link.result_tag), .end_of_conversion_n(link.end_of_conversion_n),
        .result_valid(link.result_valid));
    // Run lengths of the end-of-conversion level, in clock cycles
    always @(posedge clk_i) begin
        if (link.end_of_conversion_n !== 1'b0) begin
            hi++;
            if (lo > 0) last_lo = lo;
            lo = 0;
        end else begin
            lo++;
            if (hi > 0) last_hi = hi;
            hi = 0;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
    endtask : apb
    task automatic cmd(input logic [3:0] op, input logic [11:0] d);
        apb(1'b1, `SCS_APB_CMD, {16'h0, op, d});
    endtask : cmd
    // One manually started conversion; e is the channel the model expects
    task automatic conv(input int e, input logic sc);
        int k;
        s0 <= 14'($urandom);
        s1 <= 14'($urandom);
        apb(1'b1, `SCS_APB_CTRL, {30'h0, sc, 1'b1});
        k = 0;
        do begin
            apb(1'b0, `SCS_APB_STAT, 32'h0);
            k++;
        end while (rd[0] !== 1'b1 && k < 400);
        if (rd[0] !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        chk("irq", mask, {31'h0, irq});
        apb(1'b0, `SCS_APB_RESULT, 32'h0);
        chk("result", {17'h0, e[0], e ? s1 : s0}, rd);
        chk("low time", 1, 32'(sc ? last_lo inside {[141:144]} : last_lo == 18));
        apb(1'b1, `SCS_APB_STAT, 32'h3);
        apb(1'b0, `SCS_APB_STAT, 32'h0);
        chk("status clear", 0, {30'h0, rd[1:0]});
        chk("irq clear", 0, {31'h0, irq});
    endtask : conv
    initial begin
        void'($urandom(32'h1c5999d9));
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 1, {31'h0, err});
        chk("oscillator", 1, {31'h0, osc});
        apb(1'b0, `SCS_APB_STAT, 32'h0);
        chk("status", 0, rd);
        $display("test reset done");
        mask = 1;
        apb(1'b1, `SCS_APB_MASK, 32'h1);
        for (i = 0; i < 5; i++) begin
            if (i == 3) begin
                cmd(`SCS_CMD_WRITE_CFG, 12'hfff);
                nxt = 0;
            end
            conv(nxt, 1'b0);
            nxt ^= 1;
        end
        $display("test auto channel done");
        mask = 0;
        apb(1'b1, `SCS_APB_MASK, 32'h0);
        cmd(`SCS_CMD_WRITE_CFG, 12'h7ff);
        for (i = 0; i < 4; i++) begin
            c = $urandom_range(1);
            cmd(4'(c), 12'h000);
            conv(c, 1'b0);
            chk("channel", c, {31'h0, ch});
        end
        $display("test manual channel done");
        apb(1'b1, `SCS_APB_CTRL, 32'h2);
        cmd(`SCS_CMD_WRITE_CFG, 12'h3ff);
        cmd(`SCS_CMD_SEL_CH1, 12'h000);
        conv(1, 1'b1);
        chk("oscillator", 0, {31'h0, osc});
        cmd(`SCS_CMD_WRITE_CFG, 12'h7ff);
        apb(1'b1, `SCS_APB_CTRL, 32'h0);
        $display("test serial clock done");
        cmd(`SCS_CMD_WRITE_CFG, 12'hdff);
        repeat (100) @(posedge clk_i);
        chk("acquisition gap", 3, last_hi);
        chk("conversion time", 18, last_lo);
        cmd(`SCS_CMD_WRITE_CFG, 12'hfff);
        repeat (30) @(posedge clk_i);
        $display("test auto trigger done");
        give_verdict();
    end
endmodule : tb_top
